//--- aic_core.sv
// Local-side interrupt control/status and general control register.
// Assumes bridge events arrive as one-cycle pulses on ref_clk_i; local bus is synchronous.
`timescale 1ns/1ns
module aic_core (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_n_i,
	// Mode strap: high for PCI-initiated bus mastering
	input  wire logic                 pci_master_mode_i,
	// Local register bus
	input  wire logic [7:0]           addr_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	input  wire logic [3:0]           be_i,
	input  wire logic [31:0]          wdata_i,
	output logic [31:0]               rdata_o,
	// Bridge events, one-cycle pulses
	input  wire logic                 abort_i,
	input  wire logic                 self_test_i,
	input  wire logic                 rd_count_zero_i,
	input  wire logic                 wr_count_zero_i,
	input  wire logic [15:0]          omb_read_i,
	input  wire logic [15:0]          imb_write_i,
	// Other status the bridge shows in the general register
	input  wire logic [3:0]           self_test_code_i,
	input  wire logic [7:0]           fifo_status_i,
	// Outputs to the bridge and add-on; memory request out, answer in
	output logic                      irq_o,
	output logic                      mbox_reset_o,
	output logic                      fifo_in_reset_o,
	output logic                      fifo_out_reset_o,
	output logic                      count_enable_o,
	output aic_pkg::aic_nv_req_t      nv_req_o,
	input  wire logic                 nv_done_i,
	input  wire logic [7:0]           nv_rdata_i
);

	logic [15:0] ctl_q;
	logic [5:0]  flags;
	logic [31:0] irq_csr;
	aic_pkg::aic_irq_evt_t evt;
	logic        tce_q;
	logic        mode_seen_q;
	logic        mbox_reset_q;
	logic        fin_reset_q;
	logic        fout_reset_q;
	logic [31:0] wmask;
	logic        irq_wr;
	logic        gen_wr;
	logic        omb_hit;
	logic        imb_hit;
	logic [5:0]  flag_set;
	logic [5:0]  flag_clr;
	logic        nv_busy;
	logic [7:0]  nv_rdata;
	logic [31:0] gen_view;

	// ==========================================================
	// Bus decode
	// Byte enables expand to a bit mask so partial writes stay local
	assign wmask  = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};
	assign irq_wr = wr_i && (addr_i == aic_pkg::IRQ_CSR_OFS);
	assign gen_wr = wr_i && (addr_i == aic_pkg::GEN_CSR_OFS);

	// ==========================================================
	// Mailbox source selection
	// Pulse lines are packed box*4+byte, so the two select fields
	// concatenate straight into an index; only one byte can arm a flag.
	// outgoing box select
	assign omb_hit = omb_read_i[{ctl_q[aic_pkg::IRQ_OMB_BOX_LO +: 2],
		ctl_q[aic_pkg::IRQ_OMB_BYTE_LO +: 2]}];
	assign imb_hit = imb_write_i[{ctl_q[aic_pkg::IRQ_IMB_BOX_LO +: 2],
		ctl_q[aic_pkg::IRQ_IMB_BYTE_LO +: 2]}];

	// ==========================================================
	// Event gathering
	// Bridge pulses and mailbox matches travel together in one struct
	// whose field order follows the flag bits 21 down to 16.
	// abort event
	assign evt.abort         = abort_i;
	assign evt.self_test     = self_test_i;
	assign evt.rd_count_zero = rd_count_zero_i;
	assign evt.wr_count_zero = wr_count_zero_i;
	assign evt.omb_read      = omb_hit;
	assign evt.imb_write     = imb_hit;
	assign flag_set          = evt;
	// only ones clear
	// A clear needs byte lane 2; with that lane off every flag is left alone
	assign flag_clr = irq_wr ? (wdata_i[aic_pkg::IRQ_IMB_BIT +: 6] & wmask[aic_pkg::IRQ_IMB_BIT +: 6])
		: 6'h00;

	// ==========================================================
	// Interrupt flags, one flop per flag bit
	// A set in the same cycle as a clear wins, so an event that lands on
	// the acknowledge write is never lost; software sees it on its next read.
	for (genvar f = 0; f < $bits(flag_set); f++) begin : g_flag
		logic hold_q;
		always_ff @(posedge ref_clk_i) begin
			if (!rst_n_i) begin
				hold_q <= 1'b0;
			end else if (flag_set[f]) begin
				hold_q <= 1'b1;
			end else if (flag_clr[f]) begin
				hold_q <= 1'b0;
			end
		end
		assign flags[f] = hold_q;
	end

	// Control fields; reserved bits are never stored, so they cannot read back
	// reserved bits masked
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctl_q <= aic_pkg::IRQ_RESET[15:0];
		end else if (irq_wr) begin
			ctl_q <= (ctl_q & ~(wmask[15:0] & aic_pkg::IRQ_CTL_MASK[15:0]))
				| (wdata_i[15:0] & wmask[15:0] & aic_pkg::IRQ_CTL_MASK[15:0]);
		end
	end

	// Register image; summary and reserved bits are wiring only
	always_comb begin
		irq_csr                            = 32'h0000_0000;
		irq_csr[15:0]                      = ctl_q;
		irq_csr[aic_pkg::IRQ_IMB_BIT +: 6] = flags;
		irq_csr[aic_pkg::IRQ_SUM_BIT]      = |flags;
	end

	// ==========================================================
	// Interrupt output
	// level while enabled flag set
	// incoming enable
	// Abort and self test have no enable bit, so they always interrupt
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_csr[aic_pkg::IRQ_ABORT_BIT]
				| irq_csr[aic_pkg::IRQ_SELF_BIT]
				| (irq_csr[aic_pkg::IRQ_RDONE_BIT] & irq_csr[aic_pkg::IRQ_RDONE_EN])
				| (irq_csr[aic_pkg::IRQ_WDONE_BIT] & irq_csr[aic_pkg::IRQ_WDONE_EN])
				| (irq_csr[aic_pkg::IRQ_OMB_BIT] & irq_csr[aic_pkg::IRQ_OMB_EN])
				| (irq_csr[aic_pkg::IRQ_IMB_BIT] & irq_csr[aic_pkg::IRQ_IMB_EN]);
		end
	end

	// ==========================================================
	// General control register
	// mode-dependent reset value; the strap is sampled at the first edge after release
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tce_q       <= 1'b0;
			mode_seen_q <= 1'b0;
		end else begin
			mode_seen_q <= 1'b1;
			if (gen_wr && be_i[3]) begin
				tce_q <= wdata_i[aic_pkg::GEN_TCE_BIT];
			end
		end
	end
	assign count_enable_o = tce_q;

	// Self-clearing reset pulses, one cycle wide
	// mailbox reset pulse
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mbox_reset_q <= 1'b0;
			fin_reset_q  <= 1'b0;
			fout_reset_q <= 1'b0;
		end else begin
			mbox_reset_q <= gen_wr && be_i[3] && wdata_i[aic_pkg::GEN_MBRST_BIT];
			fin_reset_q  <= gen_wr && be_i[3] && wdata_i[aic_pkg::GEN_MBRST_BIT - 1];
			fout_reset_q <= gen_wr && be_i[3] && wdata_i[aic_pkg::GEN_MBRST_BIT - 2];
		end
	end
	assign mbox_reset_o     = mbox_reset_q;
	assign fifo_in_reset_o  = fin_reset_q;
	assign fifo_out_reset_o = fout_reset_q;

	// ==========================================================
	// Non-volatile memory access
	// go bit starts access
	aic_nv_seq u_nv_seq (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (gen_wr && be_i[3] && be_i[2] && wdata_i[aic_pkg::GEN_GO_BIT] && !nv_busy),
		.op_i       (wdata_i[aic_pkg::GEN_OPL_BIT +: 2]),
		.port_i     (wdata_i[aic_pkg::GEN_PORT_LO +: 8]),
		.busy_o     (nv_busy),
		.rdata_o    (nv_rdata),
		.nv_req_o   (nv_req_o),
		.nv_done_i  (nv_done_i),
		.nv_rdata_i (nv_rdata_i)
	);

	// Read view of the general register; pulse bits read zero.
	// Bits 7:0 show FIFO status; reset images F4h/34h differ in bits 7:6 by mode.
	always_comb begin
		gen_view                                  = 32'h0000_0000;
		gen_view[aic_pkg::GEN_GO_BIT]             = nv_busy;
		gen_view[aic_pkg::GEN_TCE_BIT]            = tce_q;
		gen_view[aic_pkg::GEN_PORT_LO +: 8]       = nv_rdata;
		gen_view[15:12]                           = self_test_code_i;
		gen_view[7:0]                             = fifo_status_i;
		if (!mode_seen_q) begin
			gen_view[7:0] = pci_master_mode_i ? aic_pkg::GEN_RESET_PCI_MASTER[7:0]
				: aic_pkg::GEN_RESET_LOCAL_MASTER[7:0];
		end
	end

	// ==========================================================
	// Read data, registered; unmapped offsets read zero
	// Registered so the local bus always sees a clean flop output
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			unique case (addr_i)
				aic_pkg::IRQ_CSR_OFS: begin
					rdata_o <= irq_csr;
				end
				aic_pkg::GEN_CSR_OFS: rdata_o <= gen_view;
				default:              rdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule // aic_core

//--- aic_pkg.sv
// Package for the local interrupt and general control block.
// Assumes a single 20 MHz clock domain and a synchronous active-low reset.
package aic_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] IRQ_CSR_OFS = 8'h38;
	localparam logic [7:0] GEN_CSR_OFS = 8'h3C;

	// ==========================================================
	// Interrupt register fields
	localparam int IRQ_SUM_BIT     = 23;
	localparam int IRQ_ABORT_BIT   = 21;
	localparam int IRQ_SELF_BIT    = 20;
	localparam int IRQ_RDONE_BIT   = 19;
	localparam int IRQ_WDONE_BIT   = 18;
	localparam int IRQ_OMB_BIT     = 17;
	localparam int IRQ_IMB_BIT     = 16;
	localparam int IRQ_RDONE_EN    = 15;
	localparam int IRQ_WDONE_EN    = 14;
	localparam int IRQ_OMB_EN      = 12;
	localparam int IRQ_OMB_BOX_LO  = 10;
	localparam int IRQ_OMB_BYTE_LO = 8;
	localparam int IRQ_IMB_EN      = 4;
	localparam int IRQ_IMB_BOX_LO  = 2;
	localparam int IRQ_IMB_BYTE_LO = 0;
	// Writable control bits: 15,14,12,11:8,4,3:0
	localparam logic [31:0] IRQ_CTL_MASK = 32'h0000_DF1F;
	// Write-one-to-clear flags: 21:16
	localparam logic [31:0] IRQ_W1C_MASK = 32'h003F_0000;
	localparam logic [31:0] IRQ_RESET    = 32'h0000_0000;

	// ==========================================================
	// General control register fields
	localparam int GEN_GO_BIT      = 31;
	localparam int GEN_OPH_BIT     = 30;
	localparam int GEN_OPL_BIT     = 29;
	localparam int GEN_TCE_BIT     = 28;
	localparam int GEN_MBRST_BIT   = 27;
	localparam int GEN_PORT_LO     = 16;
	localparam logic [31:0] GEN_RESET_PCI_MASTER   = 32'h0000_00F4;
	localparam logic [31:0] GEN_RESET_LOCAL_MASTER = 32'h0000_0034;

	// Non-volatile memory operation codes (op_high, op_low)
	typedef enum logic [1:0] {
		AIC_NV_LOAD_LO = 2'h0,
		AIC_NV_LOAD_HI = 2'h1,
		AIC_NV_WRITE   = 2'h2,
		AIC_NV_READ    = 2'h3
	} aic_nv_op_t;

	// Memory-side request towards the external byte memory
	typedef struct packed {
		logic        req;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} aic_nv_req_t;

	// Interrupt events; field order follows flag bits 21 down to 16
	typedef struct packed {
		logic abort;
		logic self_test;
		logic rd_count_zero;
		logic wr_count_zero;
		logic omb_read;
		logic imb_write;
	} aic_irq_evt_t;

endpackage : aic_pkg

//--- aic_nv_seq.sv
// Sequencer for byte-wide accesses to the external non-volatile memory.
// Assumes the memory answers each request with a one-cycle done pulse.
`timescale 1ns/1ns
module aic_nv_seq (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 start_i,
	input  wire logic [1:0]           op_i,
	input  wire logic [7:0]           port_i,
	output logic                      busy_o,
	output logic [7:0]                rdata_o,
	output aic_pkg::aic_nv_req_t      nv_req_o,
	input  wire logic                 nv_done_i,
	input  wire logic [7:0]           nv_rdata_i
);

	typedef enum logic [0:0] {AIC_IDLE, AIC_WAIT} aic_seq_state_t;
	aic_seq_state_t state_q;
	logic [15:0]    addr_q;
	logic [7:0]     wdata_q;
	logic           write_q;

	// ==========================================================
	// Command decode and memory handshake
	// decode access op
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_q <= AIC_IDLE;
			addr_q  <= 16'h0000;
			wdata_q <= 8'h00;
			write_q <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			unique case (state_q)
				AIC_IDLE: begin
					if (start_i) begin
						unique case (aic_pkg::aic_nv_op_t'(op_i))
							aic_pkg::AIC_NV_LOAD_LO: addr_q[7:0]  <= port_i;
							aic_pkg::AIC_NV_LOAD_HI: addr_q[15:8] <= port_i;
							aic_pkg::AIC_NV_WRITE: begin
								wdata_q <= port_i;
								write_q <= 1'b1;
								state_q <= AIC_WAIT;
							end
							aic_pkg::AIC_NV_READ: begin
								write_q <= 1'b0;
								state_q <= AIC_WAIT;
							end
						endcase
					end
				end
				AIC_WAIT: begin
					if (nv_done_i) begin
						state_q <= AIC_IDLE;
						if (!write_q) begin
							rdata_o <= nv_rdata_i;
						end
					end
				end
			endcase
		end
	end

	// Address loads finish at once; only memory cycles hold busy
	assign busy_o         = (state_q == AIC_WAIT);
	assign nv_req_o.req   = (state_q == AIC_WAIT);
	assign nv_req_o.write = write_q;
	assign nv_req_o.addr  = addr_q;
	assign nv_req_o.wdata = wdata_q;

endmodule // aic_nv_seq

//--- aic_nv_mem_model.sv
// Byte memory model on the far side of the nv request port.
// Assumes requests hold until the done pulse.
`timescale 1ns/1ns
module aic_nv_mem_model (
	input  wire logic			ref_clk_i,
	input  wire logic			rst_n_i,
	input  wire aic_pkg::aic_nv_req_t	nv_req_i,
	output logic				nv_done_o,
	output logic [7:0]			nv_rdata_o
);
	// ========
	// Storage and answer timing
	logic [7:0]	mem [0:65535];
	logic		act_q;
	logic		slow_q;
	logic [2:0]	cnt_q;

	// Prompt and slow answers alternate; data line toggles outside done
	always_ff @(posedge ref_clk_i) begin
		nv_done_o <= 1'b0;
		nv_rdata_o <= ~nv_rdata_o;
		if (!rst_n_i) begin
			act_q <= 1'b0;
			cnt_q <= 3'h0;
			slow_q <= 1'b0;
			nv_rdata_o <= 8'h5A;
		end else if (nv_req_i.req && !act_q) begin
			act_q <= 1'b1;
			cnt_q <= slow_q ? 3'h4 : 3'h1;
			slow_q <= !slow_q;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
			if (cnt_q == 3'h1) begin
				nv_done_o <= 1'b1;
				if (nv_req_i.write) mem[nv_req_i.addr] <= nv_req_i.wdata;
				else nv_rdata_o <= mem[nv_req_i.addr];
			end
		end else if (!nv_req_i.req) begin
			act_q <= 1'b0;
		end
	end
endmodule // aic_nv_mem_model

//--- aic_core_properties.sv
// Port assertions for the local interrupt and general control core.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/1ns
module aic_core_properties (
	input wire logic			ref_clk_i,
	input wire logic			rst_n_i,
	input wire logic [7:0]			addr_i,
	input wire logic			wr_i,
	input wire logic			rd_i,
	input wire logic [3:0]			be_i,
	input wire logic [31:0]			wdata_i,
	input wire logic [31:0]			rdata_o,
	input wire logic			abort_i,
	input wire logic			self_test_i,
	input wire logic			irq_o,
	input wire logic			mbox_reset_o,
	input wire aic_pkg::aic_nv_req_t	nv_req_o,
	input wire logic			nv_done_i
);
	// ========
	// Decoded accesses
	logic	rd_irq;
	logic	rd_gen;
	logic	wr_mbr;
	assign rd_irq = rd_i && addr_i == aic_pkg::IRQ_CSR_OFS;
	assign rd_gen = rd_i && addr_i == aic_pkg::GEN_CSR_OFS;
	assign wr_mbr = wr_i && be_i[3] && wdata_i[aic_pkg::GEN_MBRST_BIT] && addr_i == aic_pkg::GEN_CSR_OFS;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ========
	// Interrupt flags
	// abort raises irq
	abort_irq_a: assert property (abort_i |-> ##2 irq_o) else $error("abort gave no irq");
	self_irq_a: assert property (self_test_i |-> ##2 irq_o) else $error("self test gave no irq");
	sum_bit_a: assert property (rd_irq |=> rdata_o[23] == |rdata_o[21:16]) else $error("bad summary");
	rsvd_zero_a: assert property (rd_irq |=> rdata_o[31:24] == 8'h0 && !rdata_o[22] && !rdata_o[13]
		&& rdata_o[7:5] == 3'h0) else $error("reserved bit set");
	// ========
	// Mailbox reset pulse
	// write makes pulse
	mbr_pulse_a: assert property (wr_mbr |=> mbox_reset_o) else $error("no mailbox reset");
	mbr_cause_a: assert property (mbox_reset_o |-> $past(wr_mbr)) else $error("stray reset");
	mbr_read_a: assert property (rd_gen |=> !rdata_o[27]) else $error("bit 27 read one");
	// ========
	// Memory request handshake
	// request holds
	nv_hold_a: assert property (nv_req_o.req && !nv_done_i |=> nv_req_o.req) else $error("req dropped");
	nv_end_a: assert property (nv_req_o.req && nv_done_i |=> !nv_req_o.req) else $error("req stuck");

	irq_c: cover property ($rose(irq_o));
	nv_rd_c: cover property (nv_req_o.req && nv_done_i && !nv_req_o.write);
	mbr_c: cover property (mbox_reset_o);
endmodule // aic_core_properties

bind aic_core aic_core_properties aic_core_properties_i (.ref_clk_i, .rst_n_i, .addr_i, .wr_i, .rd_i, .be_i,
	.wdata_i, .rdata_o, .abort_i, .self_test_i, .irq_o, .mbox_reset_o, .nv_req_o, .nv_done_i);

//--- tb.sv
// Self-checking bench for the local interrupt and general control core.
// Assumes the byte memory model answers the core's requests.
`timescale 1ns/1ns
module tb;
	// ========
	// Design inputs and bench state
	logic			ref_clk_i;
	logic			rst_n_i;
	logic			mode;
	logic [7:0]		addr_i;
	logic			wr_i;
	logic			rd_i;
	logic [3:0]		be_i;
	logic [31:0]		wdata_i;
	logic [31:0]		rdata_o;
	logic [3:0]		evt;
	logic [15:0]		omb;
	logic [15:0]		imb;
	logic [3:0]		code;
	logic [7:0]		fifo;
	logic			irq_o;
	logic			mbr;
	logic			fin;
	logic			fout;
	logic			tce;
	aic_pkg::aic_nv_req_t	nv_req;
	logic			nv_done;
	logic [7:0]		nv_rdata;
	logic [31:0]		ctl;
	logic [31:0]		want;
	logic [31:0]		v;
	logic [3:0]		idx;
	integer			errors;
	integer			checks;
	integer			seed;
	localparam logic [7:0] IRQ = aic_pkg::IRQ_CSR_OFS;
	localparam logic [7:0] GEN = aic_pkg::GEN_CSR_OFS;

	aic_core aic_core_i (.ref_clk_i, .rst_n_i, .pci_master_mode_i(mode), .addr_i, .wr_i, .rd_i, .be_i,
		.wdata_i, .rdata_o, .abort_i(evt[0]), .self_test_i(evt[1]), .rd_count_zero_i(evt[2]),
		.wr_count_zero_i(evt[3]), .omb_read_i(omb), .imb_write_i(imb), .self_test_code_i(code),
		.fifo_status_i(fifo), .irq_o, .mbox_reset_o(mbr), .fifo_in_reset_o(fin), .fifo_out_reset_o(fout),
		.count_enable_o(tce), .nv_req_o(nv_req), .nv_done_i(nv_done), .nv_rdata_i(nv_rdata));
	aic_nv_mem_model aic_nv_mem_model_i (.ref_clk_i, .rst_n_i, .nv_req_i(nv_req), .nv_done_o(nv_done),
		.nv_rdata_o(nv_rdata));

	// 20 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// ========
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp_v);
		checks++;
		if (seen !== exp_v) begin
			errors++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp_v);
		end
	endtask
	// One bus cycle; read data is settled at the closing negedge
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge ref_clk_i);
		wr_i = w;
		rd_i = !w;
		addr_i = a;
		wdata_i = d;
		@(negedge ref_clk_i);
		wr_i = 1'b0;
		rd_i = 1'b0;
	endtask
	// Read issued on the first edge after release sees the reset value
	task automatic do_reset(input logic m);
		@(negedge ref_clk_i);
		rst_n_i = 1'b0;
		mode = m;
		repeat (4) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		rd_i = 1'b1;
		addr_i = GEN;
		@(negedge ref_clk_i);
		rd_i = 1'b0;
		chk(rdata_o, m ? 32'h0000_00F4 : 32'h0000_0034);
	endtask
	task automatic pulse(input int k, input logic [3:0] i);
		@(negedge ref_clk_i);
		if (k < 4) evt[k] = 1'b1;
		else if (k == 4) omb[i] = 1'b1;
		else imb[i] = 1'b1;
		@(negedge ref_clk_i);
		evt = 4'h0;
		omb = 16'h0;
		imb = 16'h0;
		@(negedge ref_clk_i);
	endtask
	// Go write, then poll until ready; loads never go busy
	task automatic nv(input logic [1:0] op, input logic [7:0] b);
		acc(1'b1, GEN, {1'b1, op, 5'h0, b, 16'h0});
		for (int i = 0; i < 40; i++) begin
			acc(1'b0, GEN, 32'h0);
			if (rdata_o[31] === 1'b0) break;
		end
		chk(32'(rdata_o[31]), 32'h0);
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ========
	// Main sequence
	initial begin
		seed = 32'hb63a;
		errors = 0;
		checks = 0;
		{rst_n_i, wr_i, rd_i, evt, omb, imb, code, fifo, addr_i, wdata_i} = '0;
		mode = 1'b1;
		be_i = 4'hF;
		do_reset(1'b1);
		do_reset(1'b0);
		code = 4'($random(seed));
		fifo = 8'($random(seed));
		acc(1'b0, IRQ, 32'h0);
		chk(rdata_o, 32'h0);
		repeat (6) begin
			v = $random(seed);
			acc(1'b1, IRQ, v & ~aic_pkg::IRQ_W1C_MASK);
			acc(1'b0, IRQ, 32'h0);
			chk(rdata_o, v & aic_pkg::IRQ_CTL_MASK);
		end
		// Every source with its enable on, then off
		for (int en = 1; en >= 0; en--) begin
			for (int k = 0; k < 6; k++) begin
				v = $random(seed);
				ctl = (v & 32'h0000_0F0F) | (en != 0 ? 32'h0000_D010 : 32'h0);
				acc(1'b1, IRQ, ctl);
				idx = k == 4 ? v[11:8] : v[3:0];
				if (k > 3) begin
					pulse(k, idx + 4'h1);
					acc(1'b0, IRQ, 32'h0);
					chk(rdata_o, ctl);
				end
				pulse(k, idx);
				want = ctl | (32'h1 << (21 - k)) | 32'h0080_0000;
				acc(1'b0, IRQ, 32'h0);
				chk(rdata_o, want);
				chk(32'(irq_o), 32'(en != 0 || k < 2));
				acc(1'b1, IRQ, ctl);
				acc(1'b0, IRQ, 32'h0);
				chk(rdata_o, want);
				acc(1'b1, IRQ, ctl | (32'h1 << (21 - k)));
				acc(1'b0, IRQ, 32'h0);
				chk(rdata_o, ctl);
				chk(32'(irq_o), 32'h0);
			end
		end
		// Corner: an abort on the very edge of its acknowledge write; the set wins
		@(negedge ref_clk_i);
		evt[0] = 1'b1;
		wr_i = 1'b1;
		addr_i = IRQ;
		wdata_i = 32'h0020_0000;
		@(negedge ref_clk_i);
		evt[0] = 1'b0;
		wr_i = 1'b0;
		acc(1'b0, IRQ, 32'h0);
		chk(rdata_o, 32'h00A0_0000);
		// Corner: byte lane 2 off, so the clear bit must not reach the flag
		be_i = 4'hB;
		acc(1'b1, IRQ, 32'h0020_0000);
		be_i = 4'hF;
		acc(1'b0, IRQ, 32'h0);
		chk(rdata_o, 32'h00A0_0000);
		chk(32'(irq_o), 32'h1);
		acc(1'b1, IRQ, 32'h0020_0000);
		acc(1'b0, IRQ, 32'h0);
		chk(rdata_o, 32'h0);
		chk(32'(irq_o), 32'h0);
		acc(1'b1, GEN, 32'h0800_0000);
		chk(32'({mbr, fin, fout, tce}), 32'h8);
		// Go low keeps the op bits inert; the other pulses and the count enable go out
		acc(1'b1, GEN, 32'h7600_0000);
		chk(32'({mbr, fin, fout, tce}), 32'h7);
		acc(1'b0, GEN, 32'h0);
		chk(rdata_o, {4'h1, 12'h000, code, 4'h0, fifo});
		repeat (3) begin
			v = $random(seed);
			nv(2'h0, v[7:0]);
			nv(2'h1, v[15:8]);
			nv(2'h2, v[23:16]);
			chk(32'(aic_nv_mem_model_i.mem[v[15:0]]), 32'(v[23:16]));
			nv(2'h0, v[7:0]);
			nv(2'h1, v[15:8]);
			nv(2'h3, 8'h00);
			chk(32'(rdata_o[23:16]), 32'(v[23:16]));
		end
		summarize();
	end

	// Cuts a hang far beyond the expected run of about 360 cycles
	initial begin
		#400000;
		errors++;
		summarize();
	end
endmodule // tb
